/* src/serial_port.sv */
// Purpose: Byte-wide full-duplex serial port, master or slave, APB registers.
// Assumes: Pins synchronous to clk; external clock at most clk/4 in slave mode.
// Notes:   No interrupt logic; flags are polled.
//
// The implementer's own choices: the APB interface to the registers and the address map.
`timescale 1ns/10ps
module serial_port
  import serial_port_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        sck_in,
  output logic             sck_out,
  output logic             sck_oe,
  input  wire logic        mosi_in,
  output logic             mosi_out,
  output logic             mosi_oe,
  input  wire logic        miso_in,
  output logic             miso_out,
  output logic             miso_oe,
  input  wire logic        select_n
);

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic [7:0] control;
  logic [7:0] rx_buffer;
  logic [7:0] shifter;
  logic       done_flag;
  logic       write_collision_flag_flag;
  logic       mode_fault_flag_flag;
  logic       ovf_flag;
  logic       full_flag;
  logic       master_busy;
  logic [3:0] bit_count;
  logic [3:0] div_count;
  logic       sample_bit;
  master_state_t state;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  wire access     = psel & penable;
  wire hit_data   = paddr == data_offset;
  wire hit_ctl    = paddr == control_offset;
  wire hit_sts    = paddr == status_offset;
  wire mapped     = hit_data | hit_ctl | hit_sts;
  wire wr_data    = access & pwrite & hit_data;
  wire wr_ctl     = access & pwrite & hit_ctl;
  wire wr_sts     = access & pwrite & hit_sts;
  wire rd_data    = access & ~pwrite & hit_data;
  wire [7:0] wbyte = pwdata[7:0];

  assign pready  = 1'b1;
  assign pslverr = access & ~mapped;

  // ----------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------
  wire enabled   = control[ctl_enable];
  wire is_master = control[ctl_master];
  wire cpol      = control[ctl_cpol];
  wire cpha      = control[ctl_cpha];
  wire select_line_disable     = control[ctl_select_line_disable];
  wire lsb_first = control[ctl_lsb];
  wire [1:0] rate = control[1:0];

  // Slave is selected by low select, or by enable alone when disabled
  wire slave_sel = enabled & ~is_master & (select_line_disable | ~select_n);
  wire busy      = is_master ? master_busy : (select_line_disable ? enabled : ~select_n);

  // Mode fault whenever master sees select low with select enabled
  wire mode_fault_flag_event = enabled & is_master & ~select_line_disable & ~select_n;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Half period of the serial clock in system clocks: 1, 2, 4 or 8
  function automatic logic [3:0] half_period(input logic [1:0] r);
    case (r)
      2'b00:   half_period = 4'h1;
      2'b01:   half_period = 4'h2;
      2'b10:   half_period = 4'h4;
      default: half_period = 4'h8;
    endcase
  endfunction

  // Bit presented on the outgoing line
  function automatic logic out_bit(input logic [7:0] s, input logic lsb);
    out_bit = lsb ? s[0] : s[7];
  endfunction

  // Shift one bit in at the end opposite to the one going out
  function automatic logic [7:0] shift_in(input logic [7:0] s, input logic lsb,
                                          input logic b);
    shift_in = lsb ? {b, s[7:1]} : {s[6:0], b};
  endfunction

  // ----------------------------------------------------------------
  // Master clock divider: one-cycle tick per half period
  // ----------------------------------------------------------------
  wire tick = (state != idle_st) && (div_count == half_period(rate) - 4'h1);

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      div_count <= 4'h0;
    end else if (state == idle_st || tick) begin
      div_count <= 4'h0;
    end else begin
      div_count <= div_count + 4'h1;
    end
  end

  // ----------------------------------------------------------------
  // Slave edge detection on the incoming clock (inputs are synchronous)
  // ----------------------------------------------------------------
  logic sck_prev;
  logic sel_prev;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sck_prev <= 1'b0;
      sel_prev <= 1'b0;
    end else begin
      sck_prev <= sck_in;
      sel_prev <= slave_sel;
    end
  end

  wire s_rise    = sck_in & ~sck_prev;
  wire s_fall    = ~sck_in & sck_prev;
  // Leading edge leaves the idle level, trailing edge returns to it
  wire s_lead    = slave_sel & sel_prev & (cpol ? s_fall : s_rise);
  wire s_trail   = slave_sel & sel_prev & (cpol ? s_rise : s_fall);
  wire s_sample  = cpha ? s_trail : s_lead;
  wire s_shift   = cpha ? s_lead : s_trail;
  wire s_start   = slave_sel & ~sel_prev;

  // ----------------------------------------------------------------
  // Master sample/shift points
  // ----------------------------------------------------------------
  wire m_lead    = tick & (state == lead_st);
  wire m_trail   = tick & (state == trail_st);
  wire m_sample  = cpha ? m_trail : m_lead;
  wire m_shift   = cpha ? m_lead : m_trail;
  // Phase zero samples on leads, so the eighth period ends after eight samples;
  // phase one samples on trails, so the eighth trail is itself the last sample.
  wire [3:0] last_count = cpha ? bits_per_byte - 4'h1 : bits_per_byte;
  wire m_last    = m_trail & (bit_count == last_count);
  wire m_start   = wr_data & is_master & enabled & ~master_busy;

  wire sample    = is_master ? m_sample : s_sample;
  wire shift_now = is_master ? m_shift : s_shift;
  // No shift before the first sample: the head bit is already on the line
  wire shift_ok  = shift_now & (bit_count != 4'h0);
  wire in_bit    = is_master ? miso_in : mosi_in;

  // Slave byte completes on the eighth sampling edge
  wire s_done    = ~is_master & s_sample & (bit_count == bits_per_byte - 4'h1);
  wire byte_done = m_last | s_done;
  wire last_in   = (is_master & ~cpha) ? sample_bit : in_bit;
  wire [7:0] rx_byte = shift_in(shifter, lsb_first, last_in);

  // ----------------------------------------------------------------
  // Master sequencer
  // ----------------------------------------------------------------
  master_state_t next_state;
  always_comb begin
    next_state = state;
    case (state)
      idle_st:  if (m_start) next_state = lead_st;
      lead_st:  if (tick) next_state = trail_st;
      trail_st: if (tick) next_state = m_last ? idle_st : lead_st;
      default:  next_state = idle_st;
    endcase
    if (!is_master || !enabled) next_state = idle_st;
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state <= idle_st;
    end else begin
      state <= next_state;
    end
  end

  // Busy from the starting write until the eighth period ends
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      master_busy <= 1'b0;
    end else begin
      master_busy <= (next_state != idle_st);
    end
  end

  // ----------------------------------------------------------------
  // Shift register and bit counter
  // ----------------------------------------------------------------
  // Sample latches the incoming bit; the shift edge moves it in, so the
  // outgoing bit stays stable for a full half period.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      shifter    <= 8'h00;
      sample_bit <= 1'b0;
      bit_count  <= 4'h0;
    end else if (m_start || (wr_data && !is_master && !busy)) begin
      shifter   <= wbyte;
      bit_count <= 4'h0;
    end else if (s_start || state == idle_st && is_master) begin
      bit_count <= 4'h0;
      if (byte_done) shifter <= rx_byte;
    end else begin
      if (sample) sample_bit <= in_bit;
      // Master leaves the shifter alone at the end so the line holds its last bit
      if (byte_done) begin
        if (s_done) shifter <= rx_byte;
        bit_count <= 4'h0;
      end else if (shift_ok) begin
        shifter <= shift_in(shifter, lsb_first, sample_bit);
      end
      if (sample && !byte_done) bit_count <= bit_count + 4'h1;
    end
  end

  // ----------------------------------------------------------------
  // Control register; mode fault takes enable and master away
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      control <= control_reset;
    end else begin
      if (wr_ctl) control <= wbyte;
      if (mode_fault_flag_event) begin
        control[ctl_enable] <= 1'b0;
        control[ctl_master] <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Receive buffer and status flags; a hardware set wins over a clear
  // ----------------------------------------------------------------
  wire load_buf  = byte_done & (is_master | ~full_flag);
  wire ovf_event = s_done & full_flag;
  wire write_collision_flag_event = wr_data & busy;
  wire wr_ok     = wr_data & ~busy;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rx_buffer <= 8'h00;
    end else if (load_buf) begin
      rx_buffer <= rx_byte;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      done_flag <= 1'b0;
      write_collision_flag_flag <= 1'b0;
      mode_fault_flag_flag <= 1'b0;
      ovf_flag  <= 1'b0;
      full_flag <= 1'b0;
    end else begin
      done_flag <= byte_done | (done_flag & ~(wr_sts & ~pwdata[sts_done]));
      write_collision_flag_flag <= write_collision_flag_event |
                   (write_collision_flag_flag & ~(wr_sts & ~pwdata[sts_write_collision_flag]) & ~wr_ok);
      mode_fault_flag_flag <= mode_fault_flag_event | (mode_fault_flag_flag & ~(wr_sts & ~pwdata[sts_mode_fault_flag]));
      ovf_flag  <= ovf_event |
                   (ovf_flag & ~(wr_sts & ~pwdata[sts_ovf]) & ~rd_data);
      full_flag <= load_buf |
                   (full_flag & ~rd_data & ~(wr_sts & ~pwdata[sts_full]));
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  wire [7:0] status_byte = {done_flag, write_collision_flag_flag, mode_fault_flag_flag, ovf_flag,
                            full_flag, busy, 2'b00};
  wire [7:0] read_byte = hit_data ? rx_buffer :
                         hit_ctl  ? control   :
                         hit_sts  ? status_byte : 8'h00;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= {24'h00_0000, read_byte};
    end
  end

  // ----------------------------------------------------------------
  // Pins
  // ----------------------------------------------------------------
  // Serial clock: idle level is polarity, toggles in the trailing half
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sck_out <= 1'b0;
    end else begin
      sck_out <= (next_state == trail_st) ? ~cpol : cpol;
    end
  end

  // Outgoing bit is the shifter head itself; an extra flop would move the
  // bit onto the far end's sampling edge at the fastest rate.
  wire tx_bit = out_bit(shifter, lsb_first);

  assign sck_oe   = enabled & is_master;
  assign mosi_out = tx_bit;
  assign mosi_oe  = enabled & is_master;
  assign miso_out = tx_bit;
  assign miso_oe  = slave_sel;

endmodule // serial_port

/* src/serial_port_pkg.sv */
// Purpose: Constants for the byte-wide serial master/slave port.
// Assumes: APB word-aligned registers, 25 MHz system clock.
// Notes:   Register offsets are local choices of this block.
//
// What this block does
// - Synchronous full-duplex; serial clock never faster than system clock over two.
// - Master-out line driven in master mode, input in slave mode.
// - Master-in line input in master mode, driven in slave mode.
// - Bit-order control picks MSB-first or LSB-first shifting.
// - Master generates serial clock at programmable rates; slave receives it.
// - Select is active low; four-wire slave ignores bus while select high.
// - Select-disable makes the port ignore the select line in both modes.
// - Master with select enabled sets mode fault when select is low.
// - Master-select control set means master, cleared means slave.
// - Master data write while idle loads shifter and starts full-duplex shifting.
// - Master transfer end sets done, copies byte to buffer, sets buffer full.
// - Master busy set by starting write, cleared after eighth clock period.
// - Slave transfer starts on select falling; master holds select low throughout.
// - Slave with select disabled transfers as soon as port is enabled.
// - Slave copies received byte to buffer only when buffer-full is clear.
// - Slave byte into full buffer is dropped and sets receive overrun.
// - Each slave byte sets done flag and buffer-full flag.
// - Data read or writing zero to buffer-full clears buffer-full.
// - Slave busy follows select, or port enable when select is disabled.
// - Polarity sets clock idle level; phase picks first or second edge sampling.
// - Master clock rate is system clock over 2, 4, 8 or 16.
// - Mode fault clears port enable and master select.
// - Data write while busy is dropped and sets write collision.
package serial_port_pkg;
  // Register byte offsets
  localparam logic [11:0] data_offset    = 12'h000;
  localparam logic [11:0] control_offset = 12'h004;
  localparam logic [11:0] status_offset  = 12'h008;
  // Control field positions
  localparam int ctl_enable   = 7;
  localparam int ctl_master   = 6;
  localparam int ctl_cpol     = 5;
  localparam int ctl_cpha     = 4;
  localparam int ctl_select_line_disable    = 3;
  localparam int ctl_lsb      = 2;
  localparam logic [7:0] control_reset = 8'h00;
  // Status field positions
  localparam int sts_done     = 7;
  localparam int sts_write_collision_flag     = 6;
  localparam int sts_mode_fault_flag     = 5;
  localparam int sts_ovf      = 4;
  localparam int sts_full     = 3;
  localparam int sts_busy     = 2;
  // Bits per byte shifted in each transfer
  localparam logic [3:0] bits_per_byte = 4'h8;
  typedef enum logic [1:0] {
    idle_st  = 2'b00,
    lead_st  = 2'b01,
    trail_st = 2'b11
  } master_state_t;
endpackage

/* verification/serial_far_end.sv */
// Purpose: Behavioural far-end slave for master-mode runs.
// Assumes: Selected by the bench only while one byte moves.
// Notes:   Always shifts MSB first; the bench reverses as needed.
`timescale 1ns/10ps
module serial_far_end (
  input  wire logic       sck,
  input  wire logic       mosi,
  input  wire logic       sel,
  input  wire logic       cpol,
  input  wire logic       cpha,
  input  wire logic [7:0] tx,
  output logic            miso,
  output logic      [7:0] rx
);
  // ------------------------------------------------------------
  // Edge counting and shifting
  // ------------------------------------------------------------
  int   lead;
  int   trail;
  int   idx;
  logic drv;
  // Fresh count for each selection
  always @(posedge sel) begin
    lead = 0;
    trail = 0;
  end
  // Leading edge leaves the idle level; phase picks the sampling edge
  always @(sck) begin
    if (sel) begin
      if (sck != cpol) lead++;
      else trail++;
      if ((sck != cpol) != cpha) rx = {rx[6:0], mosi};
    end
  end
  // Phase one holds the first bit through the first leading edge, then advances on each later one
  assign idx = cpha ? ((lead > 0) ? lead - 1 : 0) : trail;
  always @* begin
    if (sel) drv = tx[7 - ((idx > 7) ? 7 : idx)];
  end
  // Released line shows the inverse of the last bit, never a stale copy
  assign miso = sel ? drv : ~drv;
endmodule // serial_far_end

/* verification/serial_port_bench.sv */
// Purpose: Self-checking bench for the serial port.
// Assumes: Far end is a behavioural slave; slave runs driven here.
// Notes:   Master modes, collision, fault, slave overrun.
`timescale 1ns/10ps
module serial_port_bench
  import serial_port_pkg::*;
;
  // ------------------------------------------------------------
  // Signals and instances
  // ------------------------------------------------------------
  logic        clk, reset, psel, penable, pwrite, sck_in, mosi_in, select_n, fsel, slv, miso;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, seed;
  logic        pready, pslverr, sck_out, sck_oe, mosi_out, mosi_oe, miso_out, miso_oe;
  logic  [7:0] ctl, b, ptx, prx, mrx, sb;
  int          fails, compares, cyc, n;
  always #20 clk = ~clk;
  serial_port i_dut (.clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sck_in(sck_in), .sck_out(sck_out), .sck_oe(sck_oe), .mosi_in(mosi_in),
    .mosi_out(mosi_out), .mosi_oe(mosi_oe), .miso_in(miso), .miso_out(miso_out),
    .miso_oe(miso_oe), .select_n(select_n));
  serial_far_end i_far (.sck(sck_out), .mosi(mosi_out), .sel(fsel), .cpol(ctl[ctl_cpol]),
    .cpha(ctl[ctl_cpha]), .tx(ptx), .miso(miso), .rx(prx));
  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic [7:0] rev(input logic [7:0] v);
    return {<<{v}};
  endfunction
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Request held until pready is seen high at an edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    slv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // External master at a quarter of the system clock, mode zero
  task automatic sbyte(input logic [7:0] v);
    for (int k = 0; k < 8; k++) begin
      mosi_in <= v[7 - k];
      repeat (2) @(posedge clk);
      mrx = {mrx[6:0], miso_out};
      sck_in <= 1'b1;
      repeat (2) @(posedge clk);
      sck_in <= 1'b0;
    end
    mosi_in <= ~v[0];
    repeat (4) @(posedge clk);
  endtask
  task automatic final_report();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      final_report();
    end
  end
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    {clk, psel, penable, pwrite, sck_in, mosi_in, fsel, slv} = '0;
    {paddr, pwdata, ctl, ptx, mrx, cyc, fails, compares} = '0;
    reset = 1'b1;
    select_n = 1'b1;
    seed = 32'hf2ca;
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    apb(0, control_offset, 0); chk(rd, 32'h0);
    apb(0, status_offset, 0); chk(rd, 32'h0);
    apb(0, 12'h00c, 0); chk({rd[31:1], slv}, 32'h1);
    for (int i = 0; i < 8; i++) begin
      ctl = {2'b11, i[1], i[0] ^ i[2], 1'b0, i[2], i[1:0]};
      ptx = 8'(xs());
      b = 8'(xs());
      apb(1, control_offset, {24'h0, ctl});
      repeat (2) @(posedge clk);
      chk({31'h0, sck_out}, {31'h0, ctl[ctl_cpol]});
      fsel <= 1'b1;
      apb(1, data_offset, {24'h0, b});
      apb(1, data_offset, {24'h0, ~b});
      n = 0;
      do apb(0, status_offset, 0); while (rd[sts_busy] !== 1'b0 && ++n < 200);
      chk(rd, 32'hc8);
      apb(0, data_offset, 0); chk(rd, {24'h0, ctl[ctl_lsb] ? rev(ptx) : ptx});
      chk({24'h0, prx}, {24'h0, ctl[ctl_lsb] ? rev(b) : b});
      apb(0, status_offset, 0); chk(rd, 32'hc0);
      apb(1, status_offset, 0);
      fsel <= 1'b0;
    end
    apb(1, control_offset, 32'hc8);
    select_n <= 1'b0;
    repeat (4) @(posedge clk);
    apb(0, status_offset, 0); chk(rd, 32'h0);
    apb(1, control_offset, 32'hc0);
    repeat (4) @(posedge clk);
    apb(0, status_offset, 0); chk(rd, 32'h24);
    apb(0, control_offset, 0); chk(rd, 32'h0);
    select_n <= 1'b1;
    apb(1, status_offset, 0);
    sb = 8'(xs());
    b = 8'(xs());
    apb(1, control_offset, 32'h08);
    apb(1, data_offset, {24'h0, b});
    apb(1, control_offset, 32'h88);
    repeat (4) @(posedge clk);
    sbyte(sb);
    chk({24'h0, mrx}, {24'h0, b});
    apb(0, status_offset, 0); chk(rd, 32'h8c);
    sbyte(~sb);
    apb(0, status_offset, 0); chk(rd, 32'h9c);
    apb(0, data_offset, 0); chk(rd, {24'h0, sb});
    apb(0, status_offset, 0); chk(rd, 32'h84);
    final_report();
  end
endmodule // serial_port_bench

/* verification/serial_port_sva.sv */
// Purpose: Pin-level checks for the serial port.
// Assumes: Bound to every serial_port instance.
// Notes:   Mode bits are not visible, so checks tie pins together.
`timescale 1ns/10ps
module serial_port_sva
  import serial_port_pkg::*;
(
  input wire logic        clk,
  input wire logic        reset,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        sck_out,
  input wire logic        sck_oe,
  input wire logic        mosi_oe,
  input wire logic        miso_oe
);
  // ------------------------------------------------------------
  // Helper logic
  // ------------------------------------------------------------
  logic [5:0] edge_count;
  logic       sck_q;
  logic       data_write;
  logic       unmapped;
  // A control write may move the idle level, so it restarts the count too
  assign data_write = psel && penable && pwrite &&
                      (paddr == data_offset || paddr == control_offset);
  assign unmapped   = paddr != data_offset && paddr != control_offset && paddr != status_offset;
  // Clock edges since the last data write; a byte has sixteen at most
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      edge_count <= 6'h00;
      sck_q      <= 1'b0;
    end else begin
      sck_q      <= sck_out;
      edge_count <= data_write ? 6'h00 : edge_count + 6'((sck_oe && sck_q != sck_out) ? 1 : 0);
    end
  end
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  a_oe_pair: assert property (mosi_oe == sck_oe)
    else $error("data and clock enables differ");
  a_miso_excl: assert property (miso_oe |-> !mosi_oe && !sck_oe)
    else $error("both directions driven");
  a_slverr_map: assert property (psel && penable |-> pslverr == unmapped)
    else $error("error response wrong");
  a_unmapped_zero: assert property (psel && penable && !pwrite && unmapped |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  a_pready_high: assert property (psel && penable |-> pready)
    else $error("wait state inserted");
  a_upper_zero: assert property (prdata[31:8] == 24'h0)
    else $error("upper read bits set");
  a_byte_edges: assert property (edge_count <= 6'h10)
    else $error("too many clock edges");
  a_reset_quiet: assert property ($fell(reset) |-> !sck_oe && !miso_oe && prdata == 32'h0)
    else $error("outputs active after reset");
endmodule // serial_port_sva
bind serial_port serial_port_sva i_sva (.clk(clk), .reset(reset), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .sck_out(sck_out), .sck_oe(sck_oe), .mosi_oe(mosi_oe), .miso_oe(miso_oe));
